// File: rcsw_top.sv
// rcsw_top: rc oscillator trim, start-up sequencing and clock switch
// assumes: fuse, trim and oscillator-ok pins are asynchronous to core_clk;
// power_down comes from the sleep controller on core_clk; the register
// master follows the plain one-cycle strobe port.
//
// Operation
// - factory trim loaded into trim register at reset
// - fuse code 0010 selects rc source
// - divide-by-eight fuse divides internal clock
// - rc: 6 cycles wake, 14 reset
// - startup code adds none, 4.1ms, 65ms
// - external clock uses same delays and codes
// - trim 00 lowest, ff highest frequency
// - trim linear, about 0.4 percent steps
// - trim register read write, takes effect
// - bit 0 selects 8 or 1 mhz
// - trim step same in both ranges
// - control bits 7..1 read zero
// - watchdog keeps its own oscillator
// - software switches system clock source
// - switch only rc, external, low-power crystal; the selector here has rc and external only
// - rc running status follows oscillator
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module rcsw_top
   import rcsw_pkg::*;
#(
   parameter int FAST_CYC = `RCSW_T_FAST_US * (`RCSW_CLK_KHZ / 1000), // 4.1 ms
   parameter int SLOW_CYC = `RCSW_T_SLOW_US * (`RCSW_CLK_KHZ / 1000), // 65 ms
   parameter int CNT_W    = 22                                        // delay width
) (
   input  wire logic       core_clk,      // system clock, 50 mhz
   input  wire logic       rstn,          // async reset, active low
   input  wire logic [3:0] reg_addr,      // register address
   input  wire logic [7:0] reg_wdata,     // write data
   input  wire logic       reg_wr,        // write strobe
   input  wire logic       reg_rd,        // read strobe
   output logic      [7:0] reg_rdata,     // read data, cycle after strobe
   input  wire rcsw_fuse_s fuses,         // fuse straps, asynchronous
   input  wire logic [7:0] factory_trim,  // factory trim byte, asynchronous
   input  wire logic       rc_osc_ok,     // rc oscillator is oscillating
   input  wire logic       ext_osc_ok,    // external source is oscillating
   input  wire logic       power_down,    // sleep controller: clocks stopped
   output rcsw_osc_s       osc_ctrl,      // oscillator and gate controls
   output logic            sys_clk_tick,  // system clock enable pulse
   output logic            core_reset_n,  // core reset, active low
   output logic            cpu_clk_run,   // cpu clock may run
   output logic            wdt_osc_keep   // keep watchdog oscillator on
);

   // refuse parameters the delay counter cannot serve
   if (FAST_CYC < 1 || SLOW_CYC < FAST_CYC || SLOW_CYC >= (1 << CNT_W)) begin : g_chk
      $error("rcsw_top: delay parameters do not fit CNT_W");
   end

   localparam logic [CNT_W-1:0] BASE_LD = CNT_W'(`RCSW_BASE_CK); // reset base delay
   localparam logic [CNT_W-1:0] WAKE_LD = CNT_W'(`RCSW_WAKE_CK - 1); // wake, done cycle is last
   localparam logic [CNT_W-1:0] FAST_LD = CNT_W'(FAST_CYC);      // fast rise extra
   localparam logic [CNT_W-1:0] SLOW_LD = CNT_W'(SLOW_CYC);      // slow rise extra
   localparam logic [1:0]       FILL_N  = 2'(`RCSW_SYNC_FILL);   // sync pipe depth
   localparam logic [2:0]       GAP_N   = 3'(`RCSW_SW_GAP - 1);  // last dead cycle

   rcsw_state_s      state_r;   // registered state
   rcsw_state_s      state_nxt; // next state
   logic             dly_load;  // start a delay
   logic [CNT_W-1:0] dly_val;   // delay length
   logic             dly_done;  // delay expired
   logic             rc_run;    // rc enabled and oscillating
   logic             ext_run;   // external enabled and oscillating

   // build the word a read returns at a given offset
   function automatic logic [7:0] rd_word(input logic [3:0] a, input rcsw_state_s s,
                                          input logic rcr, input logic exr);
      logic [7:0] w;
      w = 8'h00;
      case (a)
         `RCSW_OFF_TRIM: begin
            w = s.osc.trim_code;
         end
         `RCSW_OFF_FREQ: begin
            w[`RCSW_B_FREQ] = s.osc.freq_sel;             // upper bits stay zero
         end
         `RCSW_OFF_SWCTL: begin
            w[`RCSW_B_CLOCK_SOURCE_SELECTOR]       = s.sel;
            w[`RCSW_B_EXTE]       = s.osc.ext_en;
            w[`RCSW_B_RCE]        = s.osc.rc_en;
            w[`RCSW_B_EXSUT +: 2] = s.ext_sut;
            w[`RCSW_B_RCSUT +: 2] = s.rc_sut;
         end
         `RCSW_OFF_STAT: begin
            w[`RCSW_B_EXTON] = exr;
            w[`RCSW_B_RC_RUNNING_STATUS]  = rcr;
            w[`RCSW_B_BUSY]  = (s.sw != SW_IDLE);
            w[`RCSW_B_DIV8]  = s.osc.div8;
         end
         default: begin
            w = 8'h00;                                    // unmapped reads zero
         end
      endcase
      return w;
   endfunction

   // running status: enable and synchronised oscillator-ok together
   assign rc_run  = state_r.osc.rc_en & state_r.ok2[1];
   assign ext_run = state_r.osc.ext_en & state_r.ok2[0];

   // next-state logic: synchronisers, bus, reset sequence, switch
   always_comb begin
      state_nxt         = state_r;
      dly_load          = 1'b0;
      dly_val           = '0;
      state_nxt.rd_data = 8'h00;

      // two-stage synchronisers, stage 1 read only by stage 2
      state_nxt.f1  = fuses;
      state_nxt.f2  = state_r.f1;
      state_nxt.t1  = factory_trim;
      state_nxt.t2  = state_r.t1;
      state_nxt.ok1 = {rc_osc_ok, ext_osc_ok};
      state_nxt.ok2 = state_r.ok1;

      // read: data stand only in the cycle after the strobe
      if (reg_rd) begin
         state_nxt.rd_data = rd_word(reg_addr, state_r, rc_run, ext_run);
      end

      // writes; the fuse load below overrides them during reset fill
      if (reg_wr) begin
         case (reg_addr)
            `RCSW_OFF_TRIM: begin
               // full 8-bit code, linear and same step in both ranges
               state_nxt.osc.trim_code = reg_wdata;
            end
            `RCSW_OFF_FREQ: begin
               // only bit 0 is stored, the rest is dropped
               state_nxt.osc.freq_sel = reg_wdata[`RCSW_B_FREQ];
            end
            `RCSW_OFF_SWCTL: begin
               // selector has only two targets, never the low-frequency crystal
               state_nxt.sel        = reg_wdata[`RCSW_B_CLOCK_SOURCE_SELECTOR];
               state_nxt.osc.ext_en = reg_wdata[`RCSW_B_EXTE];
               state_nxt.osc.rc_en  = reg_wdata[`RCSW_B_RCE];
               state_nxt.ext_sut    = reg_wdata[`RCSW_B_EXSUT +: 2];
            end
            default: begin
               // status and unmapped offsets ignore writes
            end
         endcase
      end

      // reset and power sequence
      case (state_r.st)
         RST_FILL: begin
            // wait for the synchronisers, then catch straps and trim
            if (state_r.fill == FILL_N) begin
               state_nxt.osc.trim_code = state_r.t2;
               state_nxt.osc.freq_sel  = `RCSW_RST_FREQ;
               state_nxt.osc.div8      = state_r.f2.div8;
               state_nxt.boot_rc       = (state_r.f2.src == `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.osc.rc_en     = (state_r.f2.src == `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.osc.ext_en    = (state_r.f2.src != `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.sel           = (state_r.f2.src != `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.act           = (state_r.f2.src != `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.osc.rc_gate   = (state_r.f2.src == `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.osc.ext_gate  = (state_r.f2.src != `RCSW_SOURCE_SELECT_FUSES_RC);
               state_nxt.rc_sut        = state_r.f2.startup_time_fuses;
               state_nxt.ext_sut       = state_r.f2.startup_time_fuses;
               dly_load                = 1'b1;
               dly_val                 = BASE_LD;
               state_nxt.st            = RST_BASE;
            end else begin
               state_nxt.fill = state_r.fill + 2'h1;
            end
         end
         RST_BASE: begin
            // 14 cycles done; add the extra delay of the boot source's code
            if (dly_done) begin
               case (state_r.boot_rc ? state_r.rc_sut : state_r.ext_sut)
                  `RCSW_SUT_FAST: begin
                     dly_load     = 1'b1;
                     dly_val      = FAST_LD;
                     state_nxt.st = RST_EXTRA;
                  end
                  `RCSW_SUT_SLOW: begin
                     dly_load     = 1'b1;
                     dly_val      = SLOW_LD;
                     state_nxt.st = RST_EXTRA;
                  end
                  default: begin
                     state_nxt.st = RST_RUN;                     // code 00, reserved 11
                  end
               endcase
            end
         end
         RST_EXTRA: begin
            // extra reset delay running
            if (dly_done) begin
               state_nxt.st = RST_RUN;
            end
         end
         RST_RUN: begin
            // running until the sleep controller stops clocks
            if (power_down) begin
               state_nxt.st = RST_SLEEP;
            end
         end
         RST_SLEEP: begin
            // leaving power-down costs the wake delay on either source
            if (!power_down) begin
               dly_load     = 1'b1;
               dly_val      = WAKE_LD;
               state_nxt.st = RST_WAKE;
            end
         end
         RST_WAKE: begin
            // wake delay running
            if (dly_done) begin
               state_nxt.st = RST_RUN;
            end
         end
         default: begin
            state_nxt.st = RST_FILL;
         end
      endcase

      // clock switch: break before make with a dead gap
      if (state_r.st != RST_FILL) begin
         case (state_r.sw)
            SW_IDLE: begin
               // a new request drops both gates at once
               if (state_r.sel != state_r.act) begin
                  state_nxt.osc.rc_gate  = 1'b0;
                  state_nxt.osc.ext_gate = 1'b0;
                  state_nxt.gap          = 3'h0;
                  state_nxt.sw           = SW_GAP;
               end
            end
            SW_GAP: begin
               // no gate open, old clock finishes its last pulse
               if (state_r.gap == GAP_N) begin
                  state_nxt.sw = SW_WAIT;
               end else begin
                  state_nxt.gap = state_r.gap + 3'h1;
               end
            end
            SW_WAIT: begin
               // open the target only once it runs
               if (state_r.sel ? ext_run : rc_run) begin
                  state_nxt.osc.rc_gate  = !state_r.sel;
                  state_nxt.osc.ext_gate = state_r.sel;
                  state_nxt.act          = state_r.sel;
                  state_nxt.sw           = SW_IDLE;
               end
            end
            default: begin
               state_nxt.sw = SW_IDLE;
            end
         endcase
      end

      // divide-by-eight prescaler makes the system clock enable;
      // next div8 is used so the fuse load never leaves a short gap
      state_nxt.pre  = state_r.pre + 3'h1;
      state_nxt.tick = state_nxt.osc.div8 ? (state_r.pre == `RCSW_PRE_LAST) : 1'b1;
   end

   // state register: constants only under reset
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r               <= '0;
         state_r.st            <= RST_FILL;
         state_r.sw            <= SW_IDLE;
         state_r.osc.trim_code <= `RCSW_RST_TRIM;
         state_r.osc.freq_sel  <= `RCSW_RST_FREQ;
      end else begin
         state_r <= state_nxt;
      end
   end

   // delay counter shared by reset, extra and wake delays
   rcsw_delay #(
      .CNT_W    (CNT_W)
   ) u_delay (
      .core_clk (core_clk),
      .rstn     (rstn),
      .load     (dly_load),
      .load_val (dly_val),
      .done     (dly_done)
   );

   // outputs
   assign reg_rdata    = state_r.rd_data;
   assign osc_ctrl     = state_r.osc;
   assign sys_clk_tick = state_r.tick;
   assign core_reset_n = (state_r.st == RST_RUN) || (state_r.st == RST_SLEEP) ||
                         (state_r.st == RST_WAKE);
   assign cpu_clk_run  = (state_r.st == RST_RUN);
   // watchdog stays on its own oscillator whatever drives the chip
   assign wdt_osc_keep = 1'b1;
endmodule

// File: rcsw_map.svh
// rcsw_map.svh: offsets, field positions, reset values and timing counts
// assumes: included by the package only; rcsw_top uses its macros without an include
`ifndef RCSW_MAP_SVH
`define RCSW_MAP_SVH

// register offsets on the plain register port
`define RCSW_OFF_TRIM   4'h0
`define RCSW_OFF_FREQ   4'h1
`define RCSW_OFF_SWCTL  4'h2
`define RCSW_OFF_STAT   4'h3

// field positions, frequency control register
`define RCSW_B_FREQ     0
// field positions, switch control register
`define RCSW_B_CLOCK_SOURCE_SELECTOR     0
`define RCSW_B_EXTE     2
`define RCSW_B_RCE      3
`define RCSW_B_EXSUT    4
`define RCSW_B_RCSUT    6
// field positions, status register
`define RCSW_B_EXTON    0
`define RCSW_B_RC_RUNNING_STATUS     1
`define RCSW_B_BUSY     2
`define RCSW_B_DIV8     3

// reset values and fuse codes
`define RCSW_RST_TRIM   8'h00
`define RCSW_RST_FREQ   1'b0
`define RCSW_SOURCE_SELECT_FUSES_RC   4'h2
`define RCSW_SUT_FAST   2'h1
`define RCSW_SUT_SLOW   2'h2

// timing: clock rate, cycle counts and times in microseconds
`define RCSW_CLK_KHZ    50000
`define RCSW_BASE_CK    14
`define RCSW_WAKE_CK    6
`define RCSW_T_FAST_US  4100
`define RCSW_T_SLOW_US  65000
`define RCSW_SYNC_FILL  2
`define RCSW_SW_GAP     4
`define RCSW_PRE_LAST   3'h7

`endif

// File: rcsw_pkg.sv
// rcsw_pkg: types shared by the rc trim and clock switch block
// assumes: rcsw_map.svh is on the include path
package rcsw_pkg;
`include "rcsw_map.svh"

   // reset and power sequence states
   typedef enum logic [2:0] {
      RST_FILL, RST_BASE, RST_EXTRA, RST_RUN, RST_SLEEP, RST_WAKE
   } rcsw_rst_e;

   // clock switch states
   typedef enum logic [1:0] {
      SW_IDLE, SW_GAP, SW_WAIT
   } rcsw_sw_e;

   // fuse straps as they arrive at the pins
   typedef struct packed {
      logic [3:0] src;   // source select fuses
      logic [1:0] startup_time_fuses;   // startup time fuses
      logic       div8;  // divide by eight fuse
   } rcsw_fuse_s;

   // controls sent to the oscillators and clock gates
   typedef struct packed {
      logic [7:0] trim_code; // rc trim code
      logic       freq_sel;  // rc output freq select, 1 = 1 mhz
      logic       rc_en;     // rc oscillator enable
      logic       ext_en;    // external clock enable
      logic       rc_gate;   // system clock from rc
      logic       ext_gate;  // system clock from external source
      logic       div8;      // internal clock divided by eight
   } rcsw_osc_s;

   // whole state of the top module
   typedef struct packed {
      rcsw_rst_e  st;        // reset sequence state
      rcsw_sw_e   sw;        // clock switch state
      logic [1:0] fill;      // synchroniser fill count
      rcsw_fuse_s f1;        // fuse sync stage 1
      rcsw_fuse_s f2;        // fuse sync stage 2
      logic [7:0] t1;        // factory trim sync stage 1
      logic [7:0] t2;        // factory trim sync stage 2
      logic [1:0] ok1;       // oscillator ok sync stage 1
      logic [1:0] ok2;       // oscillator ok sync stage 2
      logic       boot_rc;   // fuses chose the rc oscillator
      logic [1:0] rc_sut;    // rc startup code copy
      logic [1:0] ext_sut;   // external startup code
      logic       sel;       // requested source, 1 = external
      logic       act;       // source now gated through
      logic [2:0] gap;       // dead time counter
      logic [2:0] pre;       // divide by eight prescaler
      logic       tick;      // system clock enable pulse
      logic [7:0] rd_data;   // read data, one cycle after strobe
      rcsw_osc_s  osc;       // oscillator controls
   } rcsw_state_s;

endpackage

// File: rcsw_delay.sv
// rcsw_delay: loadable down counter for start-up and wake delays
// assumes: load is a one-cycle pulse from logic on core_clk
`timescale 1ns/1ps
module rcsw_delay #(
   parameter int CNT_W = 22                // counter width
) (
   input  wire logic             core_clk, // system clock
   input  wire logic             rstn,     // async reset, active low
   input  wire logic             load,     // start a new delay
   input  wire logic [CNT_W-1:0] load_val, // delay length in cycles
   output logic                  done      // counter has run out
);
   import rcsw_pkg::*;

   // all state of this counter
   typedef struct packed {
      logic [CNT_W-1:0] cnt; // cycles left
   } rcsw_dly_s;

   rcsw_dly_s state_r;   // registered state
   rcsw_dly_s state_nxt; // next state

   // refuse a width that cannot hold a count
   if (CNT_W < 4) begin : g_chk
      $error("rcsw_delay: CNT_W too small");
   end

   // load wins, otherwise count down to zero and stop
   always_comb begin
      state_nxt = state_r;
      if (load) begin
         state_nxt.cnt = load_val;
      end else if (state_r.cnt != '0) begin
         state_nxt.cnt = state_r.cnt - 1'b1;
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign done = (state_r.cnt == '0); // idle or expired
endmodule

// File: rcsw_osc_model.sv
// rcsw_osc_model: behavioural rc and external oscillators at the far side
// assumes: enables come from osc_ctrl; ok lines rise after a start-up count
`timescale 1ns/1ps
module rcsw_osc_model #(
   parameter int RC_DLY  = 3,  // rc start-up in cycles
   parameter int EXT_DLY = 12  // external start-up, slow on purpose
) (
   input  wire logic core_clk,   // system clock
   input  wire logic rc_en,      // rc oscillator enable
   input  wire logic ext_en,     // external source enable
   output logic      rc_osc_ok,  // rc oscillating
   output logic      ext_osc_ok  // external oscillating
);
   int rc_cnt  = 0; // cycles since rc enable
   int ext_cnt = 0; // cycles since external enable
   // start-up counters, cleared at once when a source is disabled
   always @(posedge core_clk) begin
      rc_cnt  <= rc_en ? rc_cnt + 1 : 0;
      ext_cnt <= ext_en ? ext_cnt + 1 : 0;
   end
   // ok lines high while enabled once the start-up count is reached
   assign rc_osc_ok  = rc_en && rc_cnt >= RC_DLY;
   assign ext_osc_ok = ext_en && ext_cnt >= EXT_DLY;
endmodule

// File: rcsw_top_assertions.sv
// rcsw_top_assertions: port-level checks of the rc trim and clock switch
// assumes: bound to rcsw_top; one clock core_clk, async reset rstn
`timescale 1ns/1ps
module rcsw_top_checker
   import rcsw_pkg::*;
#(
   parameter int FAST_CYC = 20,  // short extra delay
   parameter int SLOW_CYC = 40,  // long extra delay
   parameter int CNT_W    = 22   // delay width
) (
   input wire logic       core_clk,     // system clock
   input wire logic       rstn,         // async reset, active low
   input wire logic [3:0] reg_addr,     // register address
   input wire logic [7:0] reg_wdata,    // write data
   input wire logic       reg_wr,       // write strobe
   input wire logic       reg_rd,       // read strobe
   input wire logic [7:0] reg_rdata,    // read data
   input wire rcsw_fuse_s fuses,        // fuse straps
   input wire logic [7:0] factory_trim, // factory trim byte
   input wire logic       rc_osc_ok,    // rc oscillating
   input wire logic       ext_osc_ok,   // external oscillating
   input wire logic       power_down,   // sleep request
   input wire rcsw_osc_s  osc_ctrl,     // oscillator controls
   input wire logic       sys_clk_tick, // clock enable pulse
   input wire logic       core_reset_n, // core reset, active low
   input wire logic       cpu_clk_run,  // cpu clock runs
   input wire logic       wdt_osc_keep  // watchdog oscillator kept
);
   logic [7:0] low_cnt_r; // cycles spent in core reset
   default clocking dcb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // count core reset cycles, saturating
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) low_cnt_r <= 8'h00;
      else if (!core_reset_n && low_cnt_r != 8'hff) low_cnt_r <= low_cnt_r + 8'h01;
   end
   // both system clock gates closed
   sequence gates_shut;
      !osc_ctrl.rc_gate && !osc_ctrl.ext_gate;
   endsequence
   // one gate dropped
   sequence gate_drop;
      $fell(osc_ctrl.rc_gate) || $fell(osc_ctrl.ext_gate);
   endsequence
   chk_wdt_keep: assert property (wdt_osc_keep)
      else $error("watchdog oscillator keep dropped");
   chk_freq_zero: assert property (reg_rd && reg_addr == 4'h1 |=> reg_rdata[7:1] == 7'h00)
      else $error("reserved control bits read nonzero");
   chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data outside read answer");
   chk_trim_write: assert property (core_reset_n && reg_wr && reg_addr == 4'h0 |=> osc_ctrl.trim_code == $past(reg_wdata))
      else $error("trim write not applied");
   chk_freq_write: assert property (core_reset_n && reg_wr && reg_addr == 4'h1 |=> osc_ctrl.freq_sel == $past(reg_wdata[0]))
      else $error("freq select write not applied");
   chk_gates_excl: assert property (!(osc_ctrl.rc_gate && osc_ctrl.ext_gate))
      else $error("both clock gates open");
   chk_gate_gap: assert property (gate_drop |-> gates_shut [*5])
      else $error("gate reopened inside dead time");
   chk_tick_div: assert property (sys_clk_tick && osc_ctrl.div8 && !power_down |=> !sys_clk_tick [*7] ##1 sys_clk_tick)
      else $error("tick spacing not eight");
   chk_wake_six: assert property ($fell(power_down) && core_reset_n && !cpu_clk_run |-> !cpu_clk_run [*6] ##[1:2] cpu_clk_run)
      else $error("wake delay wrong");
   chk_reset_len: assert property ($rose(core_reset_n) |-> low_cnt_r >= 8'd16)
      else $error("core reset too short");
endmodule
bind rcsw_top rcsw_top_checker #(.FAST_CYC(FAST_CYC), .SLOW_CYC(SLOW_CYC), .CNT_W(CNT_W)) u_chk (
   .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuses(fuses),
   .factory_trim(factory_trim), .rc_osc_ok(rc_osc_ok), .ext_osc_ok(ext_osc_ok),
   .power_down(power_down), .osc_ctrl(osc_ctrl), .sys_clk_tick(sys_clk_tick),
   .core_reset_n(core_reset_n), .cpu_clk_run(cpu_clk_run), .wdt_osc_keep(wdt_osc_keep));

// File: testbench.sv
// testbench: boots, registers, clock switch and wake of rcsw_top
// assumes: oscillator model answers the enables; 50 mhz core_clk
`timescale 1ns/1ps
module testbench
   import rcsw_pkg::*;
;
   logic core_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, power_down = 0;
   logic [3:0] reg_addr = 4'h0;   // register address
   logic [7:0] reg_wdata = 8'h00; // write data
   logic [7:0] factory_trim = 8'h00, reg_rdata, v, d;
   rcsw_fuse_s fuses = '0;        // fuse straps
   rcsw_osc_s  osc_ctrl;          // oscillator controls
   logic rc_osc_ok, ext_osc_ok, sys_clk_tick, core_reset_n, cpu_clk_run, wdt_osc_keep;
   logic [31:0] seed = 32'd67;    // xorshift state
   int miscompares = 0, total_checks = 0, n, e;
   logic [6:0] cfg [5] = '{7'h11, 7'h12, 7'h15, 7'h16, 7'h02}; // src, sut, div8
   always #10 core_clk = ~core_clk;
   rcsw_top #(.FAST_CYC(20), .SLOW_CYC(40), .CNT_W(22)) dut (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fuses(fuses),
      .factory_trim(factory_trim), .rc_osc_ok(rc_osc_ok), .ext_osc_ok(ext_osc_ok),
      .power_down(power_down), .osc_ctrl(osc_ctrl), .sys_clk_tick(sys_clk_tick),
      .core_reset_n(core_reset_n), .cpu_clk_run(cpu_clk_run), .wdt_osc_keep(wdt_osc_keep));
   rcsw_osc_model u_osc (.core_clk(core_clk), .rc_en(osc_ctrl.rc_en),
      .ext_en(osc_ctrl.ext_en), .rc_osc_ok(rc_osc_ok), .ext_osc_ok(ext_osc_ok));
   // next random word
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // expected reset length for a start-up code
   function automatic int exp_delay(input logic [1:0] startup_time_fuses);
      return 17 + (startup_time_fuses == 2'h1 ? 20 : startup_time_fuses == 2'h2 ? 40 : 0);
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [3:0] a, input logic [7:0] wd);
      @(posedge core_clk);
      reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= wd;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   // one-cycle read strobe, data taken in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] q);
      @(posedge core_clk);
      reg_rd <= 1'b1; reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 q = reg_rdata;
   endtask
   // poll a status bit, bounded
   task automatic poll(input int b, input logic val);
      for (n = 0; n < 100; n++) begin
         rd(4'h3, v);
         if (v[b] === val) break;
      end
      check("status bit", v[b], val);
   endtask
   // wait for a gate to open, bounded
   task automatic wait_gate(input logic ext);
      for (n = 0; n < 60; n++) begin
         @(posedge core_clk);
         #1 if ((ext ? osc_ctrl.ext_gate : osc_ctrl.rc_gate) === 1'b1) break;
      end
      check("new gate", ext ? osc_ctrl.ext_gate : osc_ctrl.rc_gate, 1);
      check("old gate", ext ? osc_ctrl.rc_gate : osc_ctrl.ext_gate, 0);
   endtask
   // hang guard
   initial begin
      #2ms miscompares++;
      close_out();
   end
   initial begin
      // boot each start-up code and both div8 settings, ending on the external source
      foreach (cfg[i]) begin
         @(posedge core_clk);
         fuses <= rcsw_fuse_s'(cfg[i]); factory_trim <= 8'(xs()); rstn <= 1'b0;
         repeat (2) @(posedge core_clk);
         rstn <= 1'b1;
         for (n = 0; n < 200; n++) begin
            @(posedge core_clk);
            #1 if (core_reset_n === 1'b1) break;
         end
         e = exp_delay(cfg[i][2:1]);
         check("reset length", n + 1 >= e - 1 && n + 1 <= e + 3, 1);
         check("trim loaded", osc_ctrl.trim_code, factory_trim);
         check("rc gate", osc_ctrl.rc_gate, cfg[i][6:3] == 4'h2);
         check("div8", osc_ctrl.div8, cfg[i][0]);
         check("wdt keep", wdt_osc_keep, 1);
         rd(4'h0, v);
         check("trim read", v, factory_trim);
         rd(4'h1, v);
         check("freq reset", v, 8'h00);
         e = 0;
         repeat (16) begin
            @(posedge core_clk);
            #1 e += sys_clk_tick;
         end
         check("ticks", e, cfg[i][0] ? 2 : 16);
      end
      // trim register corners then random, freq register random values
      for (int i = 0; i < 8; i++) begin
         d = i == 0 ? 8'h00 : i == 1 ? 8'hff : 8'(xs());
         wr(4'h0, d);
         #1 check("trim out", osc_ctrl.trim_code, d);
         rd(4'h0, v);
         check("trim back", v, d);
         d = xs();
         wr(4'h1, d);
         rd(4'h1, v);
         check("freq back", v, {7'h00, d[0]});
         check("freq out", osc_ctrl.freq_sel, d[0]);
      end
      rd(4'hf, v);
      check("unmapped", v, 8'h00);
      // suspend: move to rc, then stop the external source
      wr(4'h2, 8'hdd);
      poll(1, 1'b1);
      rd(4'h2, v);
      check("swctl", v, 8'h5d);
      wr(4'h2, 8'h1c);
      rd(4'h3, v);
      check("stat busy", v[3:2], 2'b01);
      wait_gate(1'b0);
      wr(4'h2, 8'h18);
      poll(0, 1'b0);
      // resume: restart external, move back, stop rc
      wr(4'h2, 8'h1c);
      poll(0, 1'b1);
      wr(4'h2, 8'h1d);
      wait_gate(1'b1);
      wr(4'h2, 8'h15);
      poll(1, 1'b0);
      // power down and wake
      @(posedge core_clk);
      power_down <= 1'b1;
      repeat (4) @(posedge core_clk);
      check("sleeping", cpu_clk_run, 0);
      power_down <= 1'b0;
      for (n = 0; n < 30; n++) begin
         @(posedge core_clk);
         #1 if (cpu_clk_run === 1'b1) break;
      end
      check("woke", n >= 5 && n <= 8, 1);
      close_out();
   end
endmodule
